// ### tape_transport_mode_control.sv
// Transport mode controller: panel keys to modes, lamps and servo commands
//
// Contract
// - Each lamp is dim when off, flashing when armed, bright when active.
// - Wind-forward press enters fast forward; its lamp goes bright white.
// - Shift pressed while wind-forward held enters forward spooling instead.
// - Rewind press enters rewind; its lamp goes bright white.
// - Shift pressed while rewind held enters reverse spooling.
// - Stop in any moving mode halts tape; stop lamp bright blue.
// - Stop in unload with stop lamp flashing applies tension, lamp bright.
// - Stop with shift reverses capstan, then waits for crystal lock.
// - Play press enters play at selected speed; play lamp bright white.
// - Play during fast forward or rewind decelerates first, then plays.
// - Play in edit-ready enters dump edit.
// - Play during search flashes play lamp; play starts at search end.
// - Play with shift enters reverse play.
// - Any channel armed flashes the record lamp red.
// - Record entry by record+play or punch-in; punch-in by default.
// - Record exit by stop with record held, or play; play by default.
// - Two configuration switch bits choose the entry and exit methods.
// - Record with shift from stop enters spot erase; erase only while record re-held.
// - Record press in reverse play enters reverse erase.
// - Speed select picks high or low speed of the fitted pair.
// - Speed mode is fixed, trimmed within 50 percent, or reference locked.
// - Tension held except edit/unload; head shield up in play and record.
// - Edit press from stop gives edit-ready; again gives unload, no tension.
`timescale 1ns/100ps
module tape_transport_mode_control
    import transport_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
    parameter int CHORD_CYCLES = CHORD_CYC
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_N_I,
    // Panel keys, raw from the switches
    input wire logic [NKEYS-1:0] KEY_I,
    // Configuration and speed pins
    input wire logic PUNCH_CONFIG_SWITCH_A_I,
    input wire logic PUNCH_CONFIG_SWITCH_B_I,
    input wire logic SPEED_SELECT_I,
    input wire logic SPEED_PAIR_HIGH_I,
    input wire logic [1:0] SPEED_MODE_I,
    // Status from channels, search and servos
    input wire logic REC_READY_ANY_I,
    input wire logic SEARCH_ACTIVE_I,
    input wire logic SEARCH_DONE_I,
    input wire logic CAPSTAN_LOCKED_I,
    input wire logic TAPE_STOPPED_I,
    // Lamps, servo commands and speed
    output lamps_t LAMPS_O,
    output servo_t SERVO_O,
    output logic [6:0] SPEED_HALF_IPS_O,
    output speed_mode_t SPEED_MODE_O
);

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    logic [NKEYS-1:0] held;
    logic [NKEYS-1:0] press;
    logic [NPINS-1:0] pin_raw;
    logic [NPINS-1:0] pin_s1_r;
    logic [NPINS-1:0] pin_r;
    logic [NKEYS-1:0] pend_r;
    logic [CNT_W-1:0] win_r;
    logic win_on_r;
    logic cmd_v_r;
    logic [NKEYS-1:0] cmd_r;
    logic [NKEYS-1:0] eff;
    logic sh;
    logic play_pend_r;
    logic spot_rel_r;
    logic in_method1;
    logic out_method1;
    logic rec_ready;
    state_t state_r;
    state_t state_nxt;
    lamps_t lamps_nxt;
    servo_t servo_nxt;
    logic moving;

    // Key cleaning
    key_debounce #(
        .N(NKEYS),
        .STABLE_CYC(DEBOUNCE_CYCLES)
    ) u_keys (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .key_raw_i(KEY_I),
        .level_o(held),
        .press_o(press)
    );

    // Pin synchronisers
    assign pin_raw = {TAPE_STOPPED_I, CAPSTAN_LOCKED_I, SEARCH_DONE_I, SEARCH_ACTIVE_I,
                      REC_READY_ANY_I, SPEED_MODE_I, SPEED_PAIR_HIGH_I, SPEED_SELECT_I,
                      PUNCH_CONFIG_SWITCH_B_I, PUNCH_CONFIG_SWITCH_A_I};

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pin_s1_r <= '0;
            pin_r <= '0;
        end else begin
            pin_s1_r <= pin_raw;
            pin_r <= pin_s1_r;
        end
    end

    // Switch on selects method 1; off keeps the default method 2
    assign in_method1 = pin_r[P_CFG_A];
    assign out_method1 = pin_r[P_CFG_B];
    assign rec_ready = pin_r[P_REC_RDY];

    // Chord window: gather presses, then issue one command
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pend_r <= '0;
            win_r <= '0;
            win_on_r <= 1'b0;
            cmd_v_r <= 1'b0;
            cmd_r <= '0;
        end else begin
            cmd_v_r <= 1'b0;
            if (win_on_r && win_r == CNT_W'(CHORD_CYCLES - 1)) begin
                cmd_v_r <= 1'b1;
                cmd_r <= pend_r | press;
                pend_r <= '0;
                win_on_r <= 1'b0;
                win_r <= '0;
            end else if (win_on_r) begin
                pend_r <= pend_r | press;
                win_r <= win_r + 1'b1;
            end else if (|press) begin
                pend_r <= press;
                win_on_r <= 1'b1;
                win_r <= '0;
            end
        end
    end

    // Shift joins every key still held into the chord
    assign sh = cmd_r[K_SHIFT];
    assign eff = cmd_r | (held & {NKEYS{sh}});
    assign moving = (state_r == ST_PLAY) || (state_r == ST_RPLAY) || (state_r == ST_FFWD) ||
                    (state_r == ST_REW) || (state_r == ST_DUMP) || (state_r == ST_SPOOL_F) ||
                    (state_r == ST_SPOOL_R) || (state_r == ST_DECEL) || (state_r == ST_REC) ||
                    (state_r == ST_SPOT) || (state_r == ST_RERASE);

    // Next transport mode
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_DECEL: begin
                if (pin_r[P_STOPPED]) begin
                    state_nxt = ST_PLAY;
                end
            end
            ST_REVERSING: begin
                if (pin_r[P_LOCKED]) begin
                    state_nxt = ST_STOP;
                end
            end
            default: begin
                if (play_pend_r && pin_r[P_SRCH_DONE]) begin
                    state_nxt = ST_PLAY;
                end
            end
        endcase
        if (cmd_v_r && state_r != ST_REVERSING) begin
            if (eff[K_STOP] && sh && state_r != ST_UNLOAD && state_r != ST_EDIT_RDY) begin
                state_nxt = ST_REVERSING;
            end else if (eff[K_STOP]) begin
                if (state_r == ST_REC && out_method1 && held[K_REC]) begin
                    state_nxt = ST_PLAY;
                end else if (state_r == ST_UNLOAD) begin
                    state_nxt = ST_STOP;
                end else if (moving || state_r == ST_EDIT_RDY) begin
                    state_nxt = ST_STOP;
                end
            end else if (state_r == ST_UNLOAD || state_r == ST_EDIT_RDY) begin
                if (eff[K_EDIT] && state_r == ST_EDIT_RDY) begin
                    state_nxt = ST_UNLOAD;
                end else if (eff[K_PLAY] && state_r == ST_EDIT_RDY) begin
                    state_nxt = ST_DUMP;
                end
            end else if (eff[K_FFWD]) begin
                state_nxt = sh ? ST_SPOOL_F : ST_FFWD;
            end else if (eff[K_REW]) begin
                state_nxt = sh ? ST_SPOOL_R : ST_REW;
            end else if (eff[K_REC] && sh) begin
                if (state_r == ST_STOP) begin
                    state_nxt = ST_SPOT;
                end
            end else if (eff[K_PLAY] && sh) begin
                state_nxt = ST_RPLAY;
            end else if (eff[K_REC] && eff[K_PLAY] && in_method1 && rec_ready) begin
                state_nxt = ST_REC;
            end else if (eff[K_PLAY]) begin
                if (state_r == ST_FFWD || state_r == ST_REW) begin
                    state_nxt = ST_DECEL;
                end else if (state_r == ST_REC) begin
                    state_nxt = out_method1 ? ST_REC : ST_PLAY;
                end else if (!pin_r[P_SRCH_ACT]) begin
                    state_nxt = ST_PLAY;
                end
            end else if (eff[K_REC]) begin
                if (state_r == ST_PLAY && !in_method1 && rec_ready) begin
                    state_nxt = ST_REC;
                end else if (state_r == ST_RPLAY) begin
                    state_nxt = ST_RERASE;
                end
            end else if (eff[K_EDIT]) begin
                if (state_r == ST_STOP) begin
                    state_nxt = ST_EDIT_RDY;
                end else if (state_r == ST_PLAY) begin
                    state_nxt = ST_DUMP;
                end
            end
        end
    end

    // Mode register
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_r <= ST_STOP;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Play armed during a search; a new arming wins over the clear
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            play_pend_r <= 1'b0;
        end else if (cmd_v_r && eff[K_PLAY] && !sh && pin_r[P_SRCH_ACT]) begin
            play_pend_r <= 1'b1;
        end else if (pin_r[P_SRCH_DONE] || !pin_r[P_SRCH_ACT] || (cmd_v_r && |cmd_r)) begin
            play_pend_r <= 1'b0;
        end
    end

    // Spot erase arms once the entry press has been released
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            spot_rel_r <= 1'b0;
        end else if (state_r != ST_SPOT) begin
            spot_rel_r <= 1'b0;
        end else if (!held[K_REC]) begin
            spot_rel_r <= 1'b1;
        end
    end

    // Lamp levels from the mode
    always_comb begin
        lamps_nxt = '{default: LAMP_DIM};
        case (state_r)
            ST_FFWD, ST_SPOOL_F: lamps_nxt.ffwd = LAMP_BRIGHT;
            ST_REW, ST_SPOOL_R: lamps_nxt.rew = LAMP_BRIGHT;
            ST_STOP: lamps_nxt.stop = LAMP_BRIGHT;
            ST_PLAY, ST_RPLAY: lamps_nxt.play = LAMP_BRIGHT;
            ST_DECEL: lamps_nxt.play = LAMP_FLASH;
            ST_REC, ST_SPOT, ST_RERASE: lamps_nxt.rec = LAMP_BRIGHT;
            ST_EDIT_RDY: lamps_nxt.edit = LAMP_FLASH;
            ST_UNLOAD: lamps_nxt.stop = LAMP_FLASH;
            ST_DUMP: lamps_nxt.edit = LAMP_BRIGHT;
            ST_REVERSING: lamps_nxt.stop = LAMP_FLASH;
            default: lamps_nxt.stop = LAMP_BRIGHT;
        endcase
        if (play_pend_r) begin
            lamps_nxt.play = LAMP_FLASH;
        end
        if (rec_ready && lamps_nxt.rec == LAMP_DIM) begin
            lamps_nxt.rec = LAMP_FLASH;
        end
    end

    // Servo, shield and erase commands from the mode
    always_comb begin
        servo_nxt = '0;
        servo_nxt.reel = REEL_HOLD;
        servo_nxt.capstan_rev = SERVO_O.capstan_rev;
        servo_nxt.tension = (state_r != ST_EDIT_RDY) && (state_r != ST_UNLOAD);
        servo_nxt.shield_up = (state_r == ST_PLAY) || (state_r == ST_REC);
        case (state_r)
            ST_FFWD: servo_nxt.reel = REEL_FFWD;
            ST_REW: servo_nxt.reel = REEL_REW;
            ST_SPOOL_F: servo_nxt.reel = REEL_SPOOL_F;
            ST_SPOOL_R: servo_nxt.reel = REEL_SPOOL_R;
            ST_PLAY, ST_REC: begin
                servo_nxt.capstan_run = 1'b1;
                servo_nxt.capstan_rev = 1'b0;
                servo_nxt.record = (state_r == ST_REC);
            end
            ST_RPLAY, ST_RERASE: begin
                servo_nxt.capstan_run = 1'b1;
                servo_nxt.capstan_rev = 1'b1;
                servo_nxt.erase = (state_r == ST_RERASE);
            end
            ST_REVERSING: begin
                servo_nxt.capstan_run = 1'b1;
                servo_nxt.capstan_rev = 1'b1;
            end
            ST_SPOT: servo_nxt.erase = spot_rel_r && held[K_REC];
            ST_DUMP: begin
                servo_nxt.capstan_run = 1'b1;
                servo_nxt.capstan_rev = 1'b0;
                servo_nxt.reel = REEL_DUMP;
            end
            ST_EDIT_RDY, ST_UNLOAD: servo_nxt.reel = REEL_FREE;
            default: servo_nxt.reel = REEL_HOLD;
        endcase
    end

    // Output registers
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            LAMPS_O <= '{default: LAMP_DIM};
            SERVO_O <= '0;
        end else begin
            LAMPS_O <= lamps_nxt;
            SERVO_O <= servo_nxt;
        end
    end

    // Speed from the fitted pair and selected mode
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            SPEED_HALF_IPS_O <= HIPS_15;
            SPEED_MODE_O <= SPD_FIXED;
        end else begin
            if (pin_r[P_PAIR_HI]) begin
                SPEED_HALF_IPS_O <= pin_r[P_SPD_SEL] ? HIPS_30 : HIPS_15;
            end else begin
                SPEED_HALF_IPS_O <= pin_r[P_SPD_SEL] ? HIPS_15 : HIPS_7P5;
            end
            case (pin_r[P_MODE_HI:P_MODE_LO])
                2'h1: SPEED_MODE_O <= SPD_TRIMMED;
                2'h2: SPEED_MODE_O <= SPD_REFERENCE;
                default: SPEED_MODE_O <= SPD_FIXED;
            endcase
        end
    end

    // Checks
    property p_ffwd_lamp;
        state_r == ST_FFWD |=> LAMPS_O.ffwd == LAMP_BRIGHT;
    endproperty
    a_ffwd_lamp: assert property (p_ffwd_lamp) else $error("wind lamp not bright");

    property p_spool;
        cmd_v_r && cmd_r == 7'h40 && held[K_FFWD] && state_r == ST_FFWD |=> state_r == ST_SPOOL_F;
    endproperty
    a_spool: assert property (p_spool) else $error("shift did not spool");

    property p_stop;
        cmd_v_r && cmd_r == 7'h04 && state_r == ST_SPOOL_F |=> state_r == ST_STOP ##1
            LAMPS_O.stop == LAMP_BRIGHT;
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not halt");

    property p_unload_stop;
        cmd_v_r && cmd_r == 7'h04 && state_r == ST_UNLOAD |=> ##1 SERVO_O.tension;
    endproperty
    a_unload_stop: assert property (p_unload_stop) else $error("tension not applied");

    property p_wait_lock;
        state_r == ST_REVERSING && !pin_r[P_LOCKED] |=> state_r == ST_REVERSING;
    endproperty
    a_wait_lock: assert property (p_wait_lock) else $error("left before lock");

    property p_decel;
        cmd_v_r && cmd_r == 7'h08 && state_r == ST_REW |=> state_r == ST_DECEL;
    endproperty
    a_decel: assert property (p_decel) else $error("play skipped deceleration");

    property p_search_play;
        play_pend_r && pin_r[P_SRCH_DONE] && state_r == ST_STOP |=> state_r == ST_PLAY ##1
            LAMPS_O.play == LAMP_BRIGHT;
    endproperty
    a_search_play: assert property (p_search_play) else $error("search end did not play");

    property p_rec_flash;
        rec_ready && state_r == ST_STOP |=> LAMPS_O.rec == LAMP_FLASH;
    endproperty
    a_rec_flash: assert property (p_rec_flash) else $error("record lamp not flashing");

    property p_punch_in;
        cmd_v_r && cmd_r == 7'h10 && state_r == ST_PLAY && !in_method1 && rec_ready
            |=> state_r == ST_REC ##1 SERVO_O.record;
    endproperty
    a_punch_in: assert property (p_punch_in) else $error("punch-in failed");

    property p_tension;
        $rose(state_r == ST_UNLOAD) |=> !SERVO_O.tension && SERVO_O.reel == REEL_FREE;
    endproperty
    a_tension: assert property (p_tension) else $error("tension kept in unload");

    c_spool: cover property (state_r == ST_SPOOL_F);
    c_record: cover property (state_r == ST_REC);
    c_reverse: cover property (state_r == ST_REVERSING ##1 state_r == ST_STOP);
    c_unload: cover property (state_r == ST_UNLOAD);

endmodule

// ### transport_pkg.sv
// Shared constants, key indices and types for the transport mode controller
package transport_pkg;

    // Clock and timing
    localparam int CLK_HZ = 100_000_000;
    localparam int DEBOUNCE_MS = 10;
    localparam int CHORD_MS = 20;
    localparam int DEBOUNCE_CYC = (CLK_HZ / 1000) * DEBOUNCE_MS;
    localparam int CHORD_CYC = (CLK_HZ / 1000) * CHORD_MS;
    localparam int CNT_W = 22;

    // Panel key indices
    localparam int NKEYS = 7;
    localparam int K_FFWD = 0;
    localparam int K_REW = 1;
    localparam int K_STOP = 2;
    localparam int K_PLAY = 3;
    localparam int K_REC = 4;
    localparam int K_EDIT = 5;
    localparam int K_SHIFT = 6;

    // Synchronised pin vector layout
    localparam int NPINS = 11;
    localparam int P_CFG_A = 0;
    localparam int P_CFG_B = 1;
    localparam int P_SPD_SEL = 2;
    localparam int P_PAIR_HI = 3;
    localparam int P_MODE_LO = 4;
    localparam int P_MODE_HI = 5;
    localparam int P_REC_RDY = 6;
    localparam int P_SRCH_ACT = 7;
    localparam int P_SRCH_DONE = 8;
    localparam int P_LOCKED = 9;
    localparam int P_STOPPED = 10;

    // Tape speed in half-ips units (7-1/2 ips is 15)
    localparam logic [6:0] HIPS_30 = 7'h3c;
    localparam logic [6:0] HIPS_15 = 7'h1e;
    localparam logic [6:0] HIPS_7P5 = 7'h0f;
    localparam int TRIM_RANGE_PCT = 50;
    localparam int REF_NOMINAL_HZ = 9_600;

    typedef enum logic [1:0] {
        LAMP_DIM = 2'h0,
        LAMP_FLASH = 2'h1,
        LAMP_BRIGHT = 2'h2
    } lamp_t;

    typedef enum logic [1:0] {
        SPD_FIXED = 2'h0,
        SPD_TRIMMED = 2'h1,
        SPD_REFERENCE = 2'h2
    } speed_mode_t;

    typedef enum logic [2:0] {
        REEL_HOLD = 3'h0,
        REEL_FFWD = 3'h1,
        REEL_REW = 3'h2,
        REEL_SPOOL_F = 3'h3,
        REEL_SPOOL_R = 3'h4,
        REEL_DUMP = 3'h5,
        REEL_FREE = 3'h6
    } reel_t;

    typedef enum logic [3:0] {
        ST_STOP = 4'h0,
        ST_FFWD = 4'h1,
        ST_REW = 4'h2,
        ST_SPOOL_F = 4'h3,
        ST_SPOOL_R = 4'h4,
        ST_DECEL = 4'h5,
        ST_PLAY = 4'h6,
        ST_RPLAY = 4'h7,
        ST_REC = 4'h8,
        ST_SPOT = 4'h9,
        ST_RERASE = 4'ha,
        ST_EDIT_RDY = 4'hb,
        ST_UNLOAD = 4'hc,
        ST_DUMP = 4'hd,
        ST_REVERSING = 4'he
    } state_t;

    typedef struct packed {
        lamp_t ffwd;
        lamp_t rew;
        lamp_t stop;
        lamp_t play;
        lamp_t rec;
        lamp_t edit;
    } lamps_t;

    typedef struct packed {
        logic capstan_run;
        logic capstan_rev;
        reel_t reel;
        logic tension;
        logic shield_up;
        logic erase;
        logic record;
    } servo_t;

endpackage

// ### key_debounce.sv
// Per-key synchroniser and debouncer giving a stable level and a press pulse
`timescale 1ns/100ps
module key_debounce
    import transport_pkg::*;
#(
    parameter int N = NKEYS,
    parameter int STABLE_CYC = DEBOUNCE_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Raw keys and cleaned results
    input wire logic [N-1:0] key_raw_i,
    output logic [N-1:0] level_o,
    output logic [N-1:0] press_o
);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_key
            logic s1_r;
            logic s2_r;
            logic lvl_r;
            logic prs_r;
            logic [CNT_W-1:0] cnt_r;

            // Two-flop synchroniser
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                end else begin
                    s1_r <= key_raw_i[g];
                    s2_r <= s1_r;
                end
            end

            // Level accepted only after it holds steady; press is the rising edge
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    cnt_r <= '0;
                    lvl_r <= 1'b0;
                    prs_r <= 1'b0;
                end else begin
                    prs_r <= 1'b0;
                    if (s2_r == lvl_r) begin
                        cnt_r <= '0;
                    end else if (cnt_r == CNT_W'(STABLE_CYC - 1)) begin
                        cnt_r <= '0;
                        lvl_r <= s2_r;
                        prs_r <= s2_r;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
            end

            assign level_o[g] = lvl_r;
            assign press_o[g] = prs_r;

            property p_single_press;
                press_o[g] |=> !press_o[g];
            endproperty
            a_single_press: assert property (p_single_press) else $error("press lasted two cycles");
        end
    endgenerate

endmodule

// ### servo_model.sv
// Capstan and reel servo model giving lock and standstill status
`timescale 1ns/100ps
module servo_model
    import transport_pkg::*;
(
    // Clock, reset and response delay
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] delay_i,
    // Commands in, status out
    input wire servo_t servo_i,
    output logic locked_o,
    output logic stopped_o
);
    logic [3:0] cnt_r;
    servo_t last_r;
    logic settled;
    // Quiet cycles since the last command change
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r <= 4'h0;
            last_r <= '0;
        end else begin
            last_r <= servo_i;
            if (servo_i != last_r) begin
                cnt_r <= 4'h0;
            end else if (cnt_r != 4'hf) begin
                cnt_r <= cnt_r + 4'h1;
            end
        end
    end
    // Lock needs a running capstan, standstill idle motors, both settled
    assign settled = (servo_i == last_r) && (cnt_r >= delay_i);
    assign locked_o = settled && servo_i.capstan_run;
    assign stopped_o = settled && !servo_i.capstan_run && (servo_i.reel == REEL_HOLD);
endmodule

// ### tape_transport_mode_control_bench.sv
// Self-checking bench for the transport mode controller
`timescale 1ns/100ps
module tape_transport_mode_control_bench;
    import transport_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [6:0] keys = '0;
    logic cfg_a = 1'b0, cfg_b = 1'b0, sel = 1'b1, pair = 1'b1;
    logic rdy = 1'b0, sact = 1'b0, sdone = 1'b0;
    logic [1:0] smode = 2'h0;
    logic [3:0] dly = 4'h4;
    logic locked, stopped;
    lamps_t lamps;
    servo_t servo;
    logic [6:0] spd;
    speed_mode_t smode_o;
    int n_mismatch = 0;
    int comparisons = 0;
    // Clock generator
    always #5 clk = ~clk;
    tape_transport_mode_control #(.DEBOUNCE_CYCLES(4), .CHORD_CYCLES(8))
    u_tape_transport_mode_control (.CLK_I(clk), .RST_N_I(rst_n), .KEY_I(keys),
        .PUNCH_CONFIG_SWITCH_A_I(cfg_a), .PUNCH_CONFIG_SWITCH_B_I(cfg_b),
        .SPEED_SELECT_I(sel), .SPEED_PAIR_HIGH_I(pair), .SPEED_MODE_I(smode),
        .REC_READY_ANY_I(rdy), .SEARCH_ACTIVE_I(sact), .SEARCH_DONE_I(sdone),
        .CAPSTAN_LOCKED_I(locked), .TAPE_STOPPED_I(stopped), .LAMPS_O(lamps),
        .SERVO_O(servo), .SPEED_HALF_IPS_O(spd), .SPEED_MODE_O(smode_o));
    servo_model u_servo_model (.clk_i(clk), .rst_n_i(rst_n), .delay_i(dly),
        .servo_i(servo), .locked_o(locked), .stopped_o(stopped));
    // Drive just after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic push(input logic [6:0] m);
        keys = m;
        tick(30);
    endtask
    task automatic tap(input logic [6:0] m);
        push(m);
        push(7'h00);
    endtask
    task automatic chk(input string nm, input logic [6:0] e, input logic [6:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic finish_test;
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Wind, spool and stop for one wind key
    task automatic t_wind(input int k, input reel_t r, input reel_t rs);
        push(7'h01 << k);
        chk("reel", r, servo.reel);
        chk("wind lamp", LAMP_BRIGHT, k == K_FFWD ? lamps.ffwd : lamps.rew);
        push((7'h01 << k) | 7'h40);
        chk("spool", rs, servo.reel);
        push(7'h00);
        tap(7'h04);
        chk("stop lamp", LAMP_BRIGHT, lamps.stop);
        chk("stop reel", REEL_HOLD, servo.reel);
        $display("done wind %0d", k);
    endtask
    // Play, and play from fast wind through deceleration
    task automatic t_play;
        tap(7'h08);
        chk("play lamp", LAMP_BRIGHT, lamps.play);
        chk("shield", 1, servo.shield_up);
        chk("capstan", 1, servo.capstan_run);
        tap(7'h04);
        dly = 4'hf;
        tap(7'h02);
        keys = 7'h08;
        tick(22);
        chk("decel lamp", LAMP_FLASH, lamps.play);
        push(7'h00);
        chk("play after decel", LAMP_BRIGHT, lamps.play);
        dly = 4'h4;
        tap(7'h04);
        $display("done play");
    endtask
    // Record entry and exit by both methods
    task automatic t_rec;
        rdy = 1'b1;
        tick(5);
        chk("rec ready lamp", LAMP_FLASH, lamps.rec);
        tap(7'h08);
        tap(7'h10);
        chk("punch in", 1, servo.record);
        chk("rec lamp", LAMP_BRIGHT, lamps.rec);
        tap(7'h08);
        chk("punch out", 0, servo.record);
        tap(7'h04);
        cfg_a = 1'b1;
        cfg_b = 1'b1;
        tap(7'h18);
        chk("chord entry", 1, servo.record);
        push(7'h10);
        tap(7'h14);
        chk("stop exit", 0, servo.record);
        chk("exit to play", LAMP_BRIGHT, lamps.play);
        cfg_a = 1'b0;
        cfg_b = 1'b0;
        tap(7'h04);
        $display("done record");
    endtask
    // Reverse capstan, reverse play, reverse erase, spot erase
    task automatic t_rev;
        tap(7'h44);
        chk("reversed", 1, servo.capstan_rev);
        tap(7'h48);
        chk("rev play", 1, servo.capstan_run);
        tap(7'h10);
        chk("rev erase", 1, servo.erase);
        tap(7'h04);
        chk("halted", 0, servo.capstan_run);
        tap(7'h50);
        chk("spot idle", 0, servo.erase);
        push(7'h10);
        chk("spot held", 1, servo.erase);
        push(7'h00);
        chk("spot off", 0, servo.erase);
        tap(7'h04);
        $display("done reverse");
    endtask
    // Edit ready, dump edit, unload and tension
    task automatic t_edit;
        tap(7'h20);
        chk("edit lamp", LAMP_FLASH, lamps.edit);
        chk("no tension", 0, servo.tension);
        tap(7'h08);
        chk("dump", REEL_DUMP, servo.reel);
        tap(7'h04);
        tap(7'h20);
        tap(7'h20);
        chk("unload lamp", LAMP_FLASH, lamps.stop);
        tap(7'h04);
        chk("tension", 1, servo.tension);
        chk("stop lamp", LAMP_BRIGHT, lamps.stop);
        $display("done edit");
    endtask
    // Play armed during search, taken at search end
    task automatic t_search;
        sact = 1'b1;
        tap(7'h08);
        chk("armed", LAMP_FLASH, lamps.play);
        sdone = 1'b1;
        tick(6);
        sdone = 1'b0;
        sact = 1'b0;
        tick(6);
        chk("search play", LAMP_BRIGHT, lamps.play);
        tap(7'h04);
        $display("done search");
    endtask
    // Speed pair, select and speed mode
    task automatic t_speed;
        for (int i = 0; i < 4; i++) begin
            pair = i[1];
            sel = i[0];
            tick(6);
            chk("speed", pair ? (sel ? HIPS_30 : HIPS_15) : (sel ? HIPS_15 : HIPS_7P5), spd);
        end
        for (int m = 0; m < 3; m++) begin
            smode = m[1:0];
            tick(6);
            chk("speed mode", m[6:0], smode_o);
        end
        $display("done speed");
    endtask
    // Main sequence
    initial begin
        tick(5);
        rst_n = 1'b1;
        tick(5);
        chk("reset stop lamp", LAMP_BRIGHT, lamps.stop);
        chk("reset tension", 1, servo.tension);
        t_wind(K_FFWD, REEL_FFWD, REEL_SPOOL_F);
        t_wind(K_REW, REEL_REW, REEL_SPOOL_R);
        t_play();
        t_rec();
        t_rev();
        t_edit();
        t_search();
        t_speed();
        finish_test();
    end
    // Watchdog against a hang
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        finish_test();
    end
endmodule
